// >>> rtl/pmmd_decoder.sv
// Program memory map decoder: vectors, configuration copy and fetch routing.
// Assumes on-chip flash answers one cycle after its request, the external
// bus controller ends each access with a done pulse, straps are raw pins.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/100ps

// Contract
// - Program counter is 21 bits, byte addressing a 2-Mbyte space.
// - In on-chip-only mode, reads between top of on-chip memory and 2 Mbytes return zero.
// - Every reset loads the program counter with 0000h.
// - High-priority interrupt fetches from 0008h, low-priority from 0018h.
// - Top four flash words hold configuration, copied into registers at reset.
// - Configuration bytes ascend; words one to three used, word four reserved.
// - Configuration block starts FFF8h, 17FF8h or 1FFF8h, eight bytes long.
// - Setup byte bits 5:4 select mode; 11 means on-chip only.
// - Extended mode address width: 10 is 12, 01 is 16, 00 is 20 bits.
// - On-chip-only mode never drives the external bus; high reads return zero.
// - 64-pin parts always run on-chip only, whatever the setup bits.
// - Extended mode routes low addresses to flash, higher ones externally.
// - Data accesses use their own path, concurrent with instruction fetch.
// - Data RAM stays fully reachable in every program memory mode.
// - Setup bit 7 set disables waits; clear uses memory control wait count.
// - Setup bit 6 set selects 16-bit data, clear selects 8-bit data.
// - Setup bit 3 shifts external addresses to start at zero.
// - Setup bits 7:3 exist only on 80-pin parts; bits 2:0 read zero.
// - Shifted external address is the address minus on-chip memory size.
// - Fetch and table accesses reach external memory only in extended mode.
module pmmd_decoder
  import pmmd_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Straps from pins
  input wire logic pin80_i,
  input wire logic [1:0] size_sel_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Program counter control
  input wire logic pc_load_i,
  input wire pmmd_addr_t pc_target_i,
  input wire logic irq_hi_i,
  input wire logic irq_lo_i,
  output pmmd_addr_t pc_o,
  // Program memory access
  input wire pmmd_acc_s acc_i,
  output logic acc_ready_o,
  output logic acc_valid_o,
  output logic [15:0] acc_data_o,
  output logic cfg_done_o,
  // On-chip flash
  output pmmd_flash_s flash_o,
  input wire logic [15:0] flash_rdata_i,
  // External memory bus
  output pmmd_ext_s ext_o,
  input wire logic [15:0] ext_rdata_i,
  input wire logic ext_done_i,
  // Data memory path
  input wire pmmd_data_s data_i,
  output pmmd_data_s data_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    pmmd_state_e st;
    logic [2:0] cnt;
    logic [1:0] idx;
    logic [7:0][7:0] cfg;
    logic [7:0] setup;
    logic setup_locked;
    logic [7:0] memctl;
    pmmd_addr_t pc;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] filt;
    logic pin80;
    logic [1:0] size;
    pmmd_acc_e kind;
    logic [7:0] rdata;
    logic ready;
    logic valid;
    logic [15:0] data;
    logic done;
    pmmd_flash_s flash;
    pmmd_ext_s ext;
    pmmd_data_s dat;
  } pmmd_state_s;

  pmmd_state_s s_q;
  pmmd_state_s s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic pmmd_addr_t size_bytes(input logic [1:0] sz);
    pmmd_addr_t r;
    if (sz == PMMD_SZ_64K) begin
      r = PMMD_SIZE_64K;
    end else if (sz == PMMD_SZ_96K) begin
      r = PMMD_SIZE_96K;
    end else begin
      r = PMMD_SIZE_128K;
    end
    return r;
  endfunction

  function automatic pmmd_addr_t ext_map(input pmmd_addr_t a, input logic shift,
                                         input pmmd_addr_t sz, input logic [1:0] md);
    pmmd_addr_t r;
    // Shift first, then trim to the bus width
    r = shift ? pmmd_addr_t'(a - sz) : a;
    case (md)
      PMMD_MODE_A12: r = {9'h000, r[11:0]};
      PMMD_MODE_A16: r = {5'h00, r[15:0]};
      default: r = {1'b0, r[19:0]};
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the current configuration
  logic [1:0] mode;
  pmmd_addr_t msize;
  pmmd_addr_t a;
  logic in_chip;

  always_comb begin
    // Short packages ignore the mode bits
    mode = s_q.pin80 ? s_q.setup[PMMD_BIT_MODE_HI:PMMD_BIT_MODE_LO]
                     : PMMD_MODE_ONCHIP;
    msize = size_bytes(s_q.size);
    // Fetches use the program counter, table accesses their own address
    a = (acc_i.kind == PMMD_ACC_FETCH) ? s_q.pc : acc_i.addr;
    in_chip = (a < msize);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.valid = 1'b0;
    s_d.flash.req = 1'b0;
    s_d.flash.we = 1'b0;

    // Strap synchroniser: change accepted when stages two and three agree
    s_d.s1 = {pin80_i, size_sel_i};
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.filt = (s_q.s2 & s_q.s3) | (s_q.filt & (s_q.s2 | s_q.s3));

    // Data path runs beside the fetch path, untouched by the mode
    s_d.dat = data_i;

    // External bus setup follows the setup byte
    s_d.ext.wide = s_q.setup[PMMD_BIT_WIDE];
    s_d.ext.wait_en = ~s_q.setup[PMMD_BIT_WAIT];
    s_d.ext.wait_cnt = s_q.setup[PMMD_BIT_WAIT] ? 2'h0
        : s_q.memctl[PMMD_MEMCTL_WAIT_LO +: 2];
    s_d.ext.addr_width = mode;

    // Register reads
    s_d.rdata = 8'h00;
    if (reg_rd_i) begin
      if (reg_addr_i[3]) begin
        s_d.rdata = s_q.cfg[reg_addr_i[2:0]];
      end else begin
        case (reg_addr_i)
          PMMD_REG_SETUP: s_d.rdata = s_q.pin80 ? s_q.setup : 8'h00;
          PMMD_REG_MEMCTL: s_d.rdata = s_q.memctl;
          PMMD_REG_STATUS: s_d.rdata = {s_q.done, s_q.pin80, s_q.size, mode,
                                        s_q.setup_locked, s_q.ready};
          PMMD_REG_PC_LO: s_d.rdata = s_q.pc[7:0];
          PMMD_REG_PC_MID: s_d.rdata = s_q.pc[15:8];
          PMMD_REG_PC_HI: s_d.rdata = {3'h0, s_q.pc[20:16]};
          default: s_d.rdata = 8'h00;
        endcase
      end
    end

    // Register writes; setup byte is write-once after the copy
    if (reg_wr_i) begin
      if (reg_addr_i == PMMD_REG_MEMCTL) begin
        // Only the wait count field is kept
        s_d.memctl = reg_wdata_i & PMMD_MEMCTL_MASK;
      end
      if (reg_addr_i == PMMD_REG_SETUP && s_q.done && !s_q.setup_locked && s_q.pin80) begin
        s_d.setup = reg_wdata_i & PMMD_SETUP_MASK;
        s_d.setup_locked = 1'b1;
      end
    end

    case (s_q.st)
      PMMD_ST_SETTLE: begin
        // Count out the strap filter before trusting it
        s_d.cnt = s_q.cnt + 3'h1;
        if (s_q.cnt == PMMD_SETTLE_CYC - 3'h1) begin
          // Take the filter's next value; the registered one is a cycle late
          s_d.pin80 = s_d.filt[2];
          s_d.size = s_d.filt[1:0];
          s_d.idx = 2'h0;
          s_d.st = PMMD_ST_CFG_REQ;
        end
      end

      PMMD_ST_CFG_REQ: begin
        // Block sits in the last eight bytes of flash
        s_d.flash.req = 1'b1;
        s_d.flash.addr = 17'(msize - PMMD_CFG_SPAN + {18'h0, s_q.idx, 1'b0});
        s_d.st = PMMD_ST_CFG_WAIT;
      end

      PMMD_ST_CFG_WAIT: begin
        s_d.st = PMMD_ST_CFG_CAP;
      end

      PMMD_ST_CFG_CAP: begin
        s_d.cfg[{s_q.idx, 1'b0}] = flash_rdata_i[7:0];
        s_d.cfg[{s_q.idx, 1'b1}] = flash_rdata_i[15:8];
        // Setup byte is the low byte of word three
        if ({s_q.idx, 1'b0} == 3'(PMMD_SETUP_CFG_BYTE)) begin
          s_d.setup = flash_rdata_i[7:0] & PMMD_SETUP_MASK;
        end
        if (s_q.idx == 2'h3) begin
          s_d.done = 1'b1;
          s_d.ready = 1'b1;
          s_d.st = PMMD_ST_IDLE;
        end else begin
          s_d.idx = s_q.idx + 2'h1;
          s_d.st = PMMD_ST_CFG_REQ;
        end
      end

      PMMD_ST_IDLE: begin
        // Program counter control wins over any access
        if (pc_load_i) begin
          s_d.pc = {pc_target_i[20:1], 1'b0};
        end else if (irq_hi_i) begin
          s_d.pc = PMMD_VEC_HI;
        end else if (irq_lo_i) begin
          s_d.pc = PMMD_VEC_LO;
        end else if (acc_i.req) begin
          s_d.kind = acc_i.kind;
          if (in_chip) begin
            s_d.flash.req = 1'b1;
            s_d.flash.addr = a[16:0];
            s_d.flash.wdata = acc_i.wdata;
            if (acc_i.kind == PMMD_ACC_TBLWR) begin
              s_d.flash.we = 1'b1;
              s_d.valid = 1'b1;
              s_d.data = 16'h0000;
            end else begin
              s_d.ready = 1'b0;
              s_d.st = PMMD_ST_FL_WAIT;
            end
          end else if (mode == PMMD_MODE_ONCHIP) begin
            // No external access; reads return the no-operation word
            s_d.valid = 1'b1;
            s_d.data = 16'h0000;
            if (acc_i.kind == PMMD_ACC_FETCH) begin
              s_d.pc = pmmd_addr_t'(s_q.pc + PMMD_PC_STEP);
            end
          end else begin
            s_d.ext.req = 1'b1;
            s_d.ext.we = (acc_i.kind == PMMD_ACC_TBLWR);
            s_d.ext.addr = ext_map(a, s_q.setup[PMMD_BIT_SHIFT], msize, mode);
            s_d.ext.wdata = acc_i.wdata;
            s_d.ready = 1'b0;
            s_d.st = PMMD_ST_EXT;
          end
        end
      end

      PMMD_ST_FL_WAIT: begin
        // Flash answers one cycle after its request
        s_d.st = PMMD_ST_FL_CAP;
      end

      PMMD_ST_FL_CAP: begin
        // Fetch advances only once the word is in hand
        s_d.valid = 1'b1;
        s_d.data = flash_rdata_i;
        if (s_q.kind == PMMD_ACC_FETCH) begin
          s_d.pc = pmmd_addr_t'(s_q.pc + PMMD_PC_STEP);
        end
        s_d.ready = 1'b1;
        s_d.st = PMMD_ST_IDLE;
      end

      PMMD_ST_EXT: begin
        // Request holds until the bus controller ends it
        if (ext_done_i) begin
          s_d.ext.req = 1'b0;
          s_d.ext.we = 1'b0;
          s_d.valid = 1'b1;
          s_d.data = s_q.ext.we ? 16'h0000 : ext_rdata_i;
          if (s_q.kind == PMMD_ACC_FETCH) begin
            s_d.pc = pmmd_addr_t'(s_q.pc + PMMD_PC_STEP);
          end
          s_d.ready = 1'b1;
          s_d.st = PMMD_ST_IDLE;
        end
      end

      default: begin
        s_d.st = PMMD_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.st <= PMMD_ST_SETTLE;
      s_q.pc <= PMMD_VEC_RESET;
      // Setup byte starts with bits 7:3 set, which selects on-chip only mode
      s_q.setup <= PMMD_SETUP_RESET;
      s_q.memctl <= PMMD_MEMCTL_RESET;
      s_q.kind <= PMMD_ACC_FETCH;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata_o = s_q.rdata;
  assign pc_o = s_q.pc;
  assign acc_ready_o = s_q.ready;
  assign acc_valid_o = s_q.valid;
  assign acc_data_o = s_q.data;
  assign cfg_done_o = s_q.done;
  assign flash_o = s_q.flash;
  assign ext_o = s_q.ext;
  assign data_o = s_q.dat;

endmodule

// >>> rtl/pmmd_pkg.sv
// Program memory map decoder: shared constants, types and port bundles.
// Assumes one clock domain; all bundles are registered on the producing side.
package pmmd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Address space
  typedef logic [20:0] pmmd_addr_t;
  localparam pmmd_addr_t PMMD_VEC_RESET = 21'h000000;
  localparam pmmd_addr_t PMMD_VEC_HI = 21'h000008;
  localparam pmmd_addr_t PMMD_VEC_LO = 21'h000018;
  localparam pmmd_addr_t PMMD_SIZE_64K = 21'h010000;
  localparam pmmd_addr_t PMMD_SIZE_96K = 21'h018000;
  localparam pmmd_addr_t PMMD_SIZE_128K = 21'h020000;
  localparam pmmd_addr_t PMMD_CFG_SPAN = 21'h000008;
  localparam pmmd_addr_t PMMD_PC_STEP = 21'h000002;

  ////////////////////////////////////////////////////////////////////////////
  // Size straps
  localparam logic [1:0] PMMD_SZ_64K = 2'h0;
  localparam logic [1:0] PMMD_SZ_96K = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Bus setup byte fields
  localparam int PMMD_BIT_WAIT = 7;
  localparam int PMMD_BIT_WIDE = 6;
  localparam int PMMD_BIT_MODE_HI = 5;
  localparam int PMMD_BIT_MODE_LO = 4;
  localparam int PMMD_BIT_SHIFT = 3;
  localparam logic [7:0] PMMD_SETUP_MASK = 8'hf8;
  localparam logic [7:0] PMMD_SETUP_RESET = 8'hf8;
  localparam logic [1:0] PMMD_MODE_ONCHIP = 2'h3;
  localparam logic [1:0] PMMD_MODE_A12 = 2'h2;
  localparam logic [1:0] PMMD_MODE_A16 = 2'h1;
  localparam logic [7:0] PMMD_MEMCTL_MASK = 8'h30;
  localparam logic [7:0] PMMD_MEMCTL_RESET = 8'h00;
  localparam int PMMD_MEMCTL_WAIT_LO = 4;
  localparam int PMMD_SETUP_CFG_BYTE = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [3:0] PMMD_REG_SETUP = 4'h0;
  localparam logic [3:0] PMMD_REG_MEMCTL = 4'h1;
  localparam logic [3:0] PMMD_REG_STATUS = 4'h2;
  localparam logic [3:0] PMMD_REG_PC_LO = 4'h3;
  localparam logic [3:0] PMMD_REG_PC_MID = 4'h4;
  localparam logic [3:0] PMMD_REG_PC_HI = 4'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam logic [2:0] PMMD_SETTLE_CYC = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    PMMD_ACC_FETCH = 2'b00,
    PMMD_ACC_TBLRD = 2'b01,
    PMMD_ACC_TBLWR = 2'b10
  } pmmd_acc_e;

  typedef enum logic [2:0] {
    PMMD_ST_SETTLE = 3'b000,
    PMMD_ST_CFG_REQ = 3'b001,
    PMMD_ST_CFG_WAIT = 3'b010,
    PMMD_ST_CFG_CAP = 3'b011,
    PMMD_ST_IDLE = 3'b100,
    PMMD_ST_FL_WAIT = 3'b101,
    PMMD_ST_FL_CAP = 3'b110,
    PMMD_ST_EXT = 3'b111
  } pmmd_state_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [16:0] addr;
    logic [7:0] wdata;
  } pmmd_flash_s;

  typedef struct packed {
    logic req;
    logic we;
    pmmd_addr_t addr;
    logic [7:0] wdata;
    logic wide;
    logic wait_en;
    logic [1:0] wait_cnt;
    logic [1:0] addr_width;
  } pmmd_ext_s;

  typedef struct packed {
    logic req;
    pmmd_acc_e kind;
    pmmd_addr_t addr;
    logic [7:0] wdata;
  } pmmd_acc_s;

  typedef struct packed {
    logic req;
    logic [11:0] addr;
  } pmmd_data_s;

endpackage

// >>> dv/pmmd_mem_model.sv
// Far-side model: on-chip flash image with configuration block, external memory.
// Assumes the bench supplies flash top, setup byte image and bus latency.
`timescale 1ns/100ps
module pmmd_mem_model
  import pmmd_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Image setup
  input wire pmmd_addr_t top_i,
  input wire logic [7:0] cfg_i,
  input wire logic [1:0] dly_i,
  // Flash side
  input wire pmmd_flash_s flash_i,
  output logic [15:0] flash_rdata_o,
  // External side
  input wire pmmd_ext_s ext_i,
  output logic [15:0] ext_rdata_o,
  output logic ext_done_o
);
  logic [1:0] cnt_q;
  pmmd_addr_t fa;
  assign fa = {4'h0, flash_i.addr};
  function automatic logic [7:0] fbyte(input pmmd_addr_t a);
    fbyte = (a == top_i - 21'h4) ? cfg_i : a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
      ext_done_o <= 1'b0;
      flash_rdata_o <= 16'h0000;
      ext_rdata_o <= 16'h0000;
    end else begin
      if (flash_i.req) begin
        flash_rdata_o <= {fbyte(fa + 21'h1), fbyte(fa)};
      end else begin
        flash_rdata_o <= ~flash_rdata_o;
      end
      if (ext_done_o) begin
        ext_done_o <= 1'b0;
        cnt_q <= 2'h0;
        ext_rdata_o <= ~ext_rdata_o;
      end else if (ext_i.req && cnt_q == dly_i) begin
        ext_done_o <= 1'b1;
        ext_rdata_o <= {ext_i.addr[7:0], ext_i.addr[15:8]} ^ 16'ha55a;
      end else begin
        cnt_q <= cnt_q + {1'b0, ext_i.req};
        ext_rdata_o <= ~ext_rdata_o;
      end
    end
  end
endmodule

// >>> dv/pmmd_decoder_props.sv
// Port-level checker for the program memory map decoder.
// Assumes ce_i high during checking; bound to every decoder instance.
`timescale 1ns/100ps
module pmmd_decoder_props
  import pmmd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic pin80_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic pc_load_i,
  input wire logic irq_hi_i,
  input wire logic irq_lo_i,
  input wire pmmd_addr_t pc_o,
  input wire logic acc_ready_o,
  input wire logic acc_valid_o,
  input wire logic cfg_done_o,
  input wire pmmd_ext_s ext_o,
  input wire logic ext_done_i,
  input wire pmmd_data_s data_i,
  input wire pmmd_data_s data_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  AST_CFG_PC: assert property ($rose(cfg_done_o) |-> pc_o == 21'h0)
    else $error("pc not at reset vector when setup copy ends");
  AST_CFG_TIME: assert property ($fell(rst_i) |-> ##[1:40] cfg_done_o)
    else $error("setup copy did not finish");
  AST_NO_EARLY: assert property (!cfg_done_o |-> !acc_ready_o && !ext_o.req)
    else $error("access possible before setup copy");
  AST_VEC_HI: assert property (irq_hi_i && acc_ready_o && !pc_load_i |=> pc_o == 21'h8)
    else $error("high vector wrong");
  AST_VEC_LO: assert property (irq_lo_i && acc_ready_o && !pc_load_i && !irq_hi_i
    |=> pc_o == 21'h18)
    else $error("low vector wrong");
  AST_DATA_PATH: assert property (data_i.req |=> data_o == $past(data_i))
    else $error("data path copy wrong");
  AST_EXT_HOLD: assert property (ext_o.req && !ext_done_i
    |=> ext_o.req && $stable(ext_o.addr))
    else $error("external request dropped early");
  AST_EXT_END: assert property (ext_o.req && ext_done_i
    |=> !ext_o.req && acc_valid_o)
    else $error("external access did not finish");
  AST_EXT_MODE: assert property (ext_o.req
    |-> pin80_i && ext_o.addr_width != 2'h3)
    else $error("external bus used in on-chip mode");
  AST_WAIT_OFF: assert property (ext_o.req && !ext_o.wait_en
    |-> ext_o.wait_cnt == 2'h0)
    else $error("wait count with waits off");
  AST_SETUP_LOW: assert property (reg_rd_i && reg_addr_i == PMMD_REG_SETUP
    |=> reg_rdata_o[2:0] == 3'h0)
    else $error("setup low bits not zero");
  COV_EXT: cover property (ext_o.req && ext_done_i);
  COV_HI: cover property (irq_hi_i && acc_ready_o);
  COV_CFG: cover property ($rose(cfg_done_o));
endmodule
bind pmmd_decoder pmmd_decoder_props u_pmmd_decoder_props (.mclk_i, .rst_i, .pin80_i,
  .reg_addr_i, .reg_rd_i, .reg_rdata_o, .pc_load_i, .irq_hi_i, .irq_lo_i, .pc_o,
  .acc_ready_o, .acc_valid_o, .cfg_done_o, .ext_o, .ext_done_i, .data_i, .data_o);

// >>> dv/pmmd_decoder_bench.sv
// Self-checking bench for the program memory map decoder.
// Assumes the memory model on the flash and external sides; ce_i held high.
`timescale 1ns/100ps
module pmmd_decoder_bench;
  import pmmd_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pin80_i = 1'b1;
  logic [1:0] size_sel_i = 2'h0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic pc_load_i = 1'b0;
  pmmd_addr_t pc_target_i = 21'h000401;
  logic irq_hi_i = 1'b0;
  logic irq_lo_i = 1'b0;
  pmmd_acc_s acc_i = '0;
  pmmd_data_s data_i = '0;
  logic [1:0] dly = 2'h0;
  logic [7:0] reg_rdata_o;
  pmmd_addr_t pc_o;
  logic acc_ready_o, acc_valid_o, cfg_done_o, ext_done_i;
  logic [15:0] acc_data_o, flash_rdata_i, ext_rdata_i;
  pmmd_flash_s flash_o;
  pmmd_ext_s ext_o;
  pmmd_data_s data_o;
  pmmd_addr_t top = PMMD_SIZE_64K;
  logic [7:0] cfg = 8'h08;
  logic [7:0] set;
  logic [31:0] seed = 32'h2daf3142;
  logic [31:0] dseed = 32'h2daf3142;
  int num_errors = 0;
  int total_checks = 0;
  always #2 mclk_i = ~mclk_i;

  pmmd_decoder u_pmmd_decoder (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1),
    .pin80_i(pin80_i), .size_sel_i(size_sel_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pc_load_i(pc_load_i), .pc_target_i(pc_target_i),
    .irq_hi_i(irq_hi_i), .irq_lo_i(irq_lo_i), .pc_o(pc_o), .acc_i(acc_i),
    .acc_ready_o(acc_ready_o), .acc_valid_o(acc_valid_o), .acc_data_o(acc_data_o),
    .cfg_done_o(cfg_done_o), .flash_o(flash_o), .flash_rdata_i(flash_rdata_i),
    .ext_o(ext_o), .ext_rdata_i(ext_rdata_i), .ext_done_i(ext_done_i),
    .data_i(data_i), .data_o(data_o));
  pmmd_mem_model u_pmmd_mem_model (.mclk_i(mclk_i), .rst_i(rst_i), .top_i(top),
    .cfg_i(cfg), .dly_i(dly), .flash_i(flash_o), .flash_rdata_o(flash_rdata_i),
    .ext_i(ext_o), .ext_rdata_o(ext_rdata_i), .ext_done_o(ext_done_i));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] fb(input pmmd_addr_t a);
    fb = (a == top - 21'h4) ? cfg : a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  function automatic logic [15:0] exp_word(input pmmd_addr_t a);
    pmmd_addr_t ea;
    ea = set[3] ? a - top : a;
    if (set[5:4] == 2'h2) ea = ea & 21'h000fff;
    else if (set[5:4] == 2'h1) ea = ea & 21'h00ffff;
    else ea = ea & 21'h0fffff;
    if (a < top) exp_word = {fb(a + 21'h1), fb(a)};
    else if (!pin80_i || set[5:4] == 2'h3) exp_word = 16'h0000;
    else exp_word = {ea[7:0], ea[15:8]} ^ 16'ha55a;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 chk("reg_rdata", reg_rdata_o, e);
  endtask
  task automatic wait_rdy();
    for (int n = 0; n < 60 && acc_ready_o !== 1'b1; n++) @(posedge mclk_i) #1;
    chk("acc_ready", acc_ready_o, 1'b1);
  endtask
  task automatic acc(input pmmd_acc_e k, input pmmd_addr_t a, input logic [15:0] e);
    wait_rdy();
    @(posedge mclk_i);
    acc_i <= '{1'b1, k, a, seed[7:0]};
    @(posedge mclk_i);
    acc_i.req <= 1'b0;
    #1;
    for (int n = 0; n < 60 && acc_valid_o !== 1'b1; n++) @(posedge mclk_i) #1;
    chk("acc_data", acc_data_o, e);
  endtask
  task automatic pulse(input int w, input pmmd_addr_t e);
    wait_rdy();
    @(posedge mclk_i);
    pc_load_i <= (w == 0);
    irq_hi_i <= (w == 1);
    irq_lo_i <= (w == 2);
    @(posedge mclk_i);
    {pc_load_i, irq_hi_i, irq_lo_i} <= 3'h0;
    #1 chk("pc", pc_o, e);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk_i) begin
    dseed <= lfsr(dseed);
    data_i <= {dseed[12], dseed[11:0]};
    dly <= dseed[14:13];
  end
  initial begin
    // Four runs of at most a few hundred cycles each
    #(20000 * 4);
    num_errors++;
    close_out();
  end
  initial begin
    logic [7:0] cfg_tab [4] = '{8'h08, 8'h58, 8'hf8, 8'h08};
    pmmd_addr_t top_tab [4] = '{PMMD_SIZE_64K, PMMD_SIZE_96K, PMMD_SIZE_128K, PMMD_SIZE_128K};
    pmmd_addr_t a;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      rst_i <= 1'b1;
      pin80_i <= (i != 3);
      size_sel_i <= (i > 1) ? 2'h2 : i[1:0];
      cfg <= cfg_tab[i];
      top <= top_tab[i];
      repeat (5) @(posedge mclk_i);
      rst_i <= 1'b0;
      #1 chk("cfg_done", cfg_done_o, 1'b0);
      chk("pc", pc_o, PMMD_VEC_RESET);
      wait_rdy();
      set = pin80_i ? (cfg & 8'hf8) : 8'h00;
      rd(PMMD_REG_SETUP, set);
      rd(PMMD_REG_STATUS, {1'b1, pin80_i, size_sel_i,
        pin80_i ? set[5:4] : 2'h3, 2'h1});
      for (int j = 0; j < 8; j++) rd(4'h8 + j[3:0], fb(top - 8 + j));
      acc(PMMD_ACC_FETCH, 21'h0, exp_word(21'h0));
      pulse(1, PMMD_VEC_HI);
      pulse(2, PMMD_VEC_LO);
      acc(PMMD_ACC_FETCH, 21'h0, exp_word(21'h18));
      acc(PMMD_ACC_FETCH, 21'h0, exp_word(21'h1a));
      pulse(0, 21'h000400);
      rd(PMMD_REG_PC_MID, 8'h04);
      rd(PMMD_REG_PC_LO, 8'h00);
      acc(PMMD_ACC_TBLWR, 21'h000100, 16'h0000);
      repeat (6) begin
        seed = lfsr(seed);
        a = {seed[20:1], 1'b0};
        if (seed[31]) a = a & (top - 21'h1);
        acc(PMMD_ACC_TBLRD, a, exp_word(a));
      end
      wr(PMMD_REG_MEMCTL, 8'hff);
      rd(PMMD_REG_MEMCTL, 8'h30);
      wr(PMMD_REG_SETUP, 8'he7);
      if (pin80_i) set = 8'he0;
      rd(PMMD_REG_SETUP, set);
      chk("ext_wide", ext_o.wide, set[6]);
      chk("ext_wait_en", ext_o.wait_en, !set[7]);
      chk("ext_wait_cnt", ext_o.wait_cnt, set[7] ? 2'h0 : 2'h3);
      chk("ext_width", ext_o.addr_width, pin80_i ? set[5:4] : 2'h3);
      wr(PMMD_REG_SETUP, 8'h08);
      rd(PMMD_REG_SETUP, set);
      acc(PMMD_ACC_TBLRD, 21'h1a3456, exp_word(21'h1a3456));
      acc(PMMD_ACC_FETCH, 21'h0, exp_word(21'h400));
      rd(4'h6, 8'h00);
    end
    close_out();
  end
endmodule
